// [pkg/dma_done_defs.vh]
// How it works
// - a channel's status bit sets when its last write reaches memory.
// - a set status bit holds at one; only a software write or reset clears it.
// - writing one to a status bit position clears that bit, unless its done event fires in the same cycle.
// - status register sits at offset 58h and resets to all zero.
// - bits 31..28 are input 2 port B mux sources 3..0.
// - bits 27..12 are input 2 port A mux sources 15..0.
// - bits 11..6 are input 1 rgb b, rgb a, chroma b, luma b, chroma a, luma a.
// - bits 5..0 are input 1 port B ancillary sources 15..10.
// - a done event implies the client buffer is drained; the source guarantees it.
// - an event drives the irq line only while its mask bit is one.
`ifndef DMA_DONE_DEFS_VH
`define DMA_DONE_DEFS_VH
// ==========================================================
// register map
`define DONE_STATUS_OFS 8'h58
`define DONE_MASK_OFS 8'h5C
`define DONE_RESET_VAL 32'h0000_0000
// ==========================================================
// field positions
`define IN2_PORTB_HI 31
`define IN2_PORTB_LO 28
`define IN2_PORTA_HI 27
`define IN2_PORTA_LO 12
`define IN1_PORTB_RGB_BIT 11
`define IN1_PORTA_RGB_BIT 10
`define IN1_PORTB_CHROMA_BIT 9
`define IN1_PORTB_LUMA_BIT 8
`define IN1_PORTA_CHROMA_BIT 7
`define IN1_PORTA_LUMA_BIT 6
`define IN1_ANC_HI 5
`define IN1_ANC_LO 0
// ==========================================================
// widths and levels
`define DONE_REG_W 32
`define DONE_BIT_SET 1'b1
`define DONE_BIT_CLR 1'b0
`define DONE_IRQ_IDLE 1'b0
`define DONE_IRQ_ACTIVE 1'b1
`endif

// [rtl/dma_write_done_irq_status.v]
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "dma_done_defs.vh"
module dma_write_done_irq_status #(
    parameter ADDR_W = 8
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [3:0] in2_portb_mux_done,
    input wire [15:0] in2_porta_mux_done,
    input wire in1_portb_rgb_done,
    input wire in1_porta_rgb_done,
    input wire in1_portb_chroma_done,
    input wire in1_portb_luma_done,
    input wire in1_porta_chroma_done,
    input wire in1_porta_luma_done,
    input wire [5:0] in1_portb_anc_done,
    output reg dma_irq_line_zero
);
    // ==========================================================
    // local sizes
    // the word width follows the header, so the map is defined in one place
    localparam DATA_W = `DONE_REG_W;

    // ==========================================================
    // event gathering
    // done strobes come from the dma engine on this clock, so no synchroniser;
    // the engine only pulses once the client has drained
    wire [DATA_W-1:0] done_evt;

    // ==========================================================
    // input 2 port b, lower chroma client
    wire in2_pb_src3_evt;
    wire in2_pb_src2_evt;
    wire in2_pb_src1_evt;
    wire in2_pb_src0_evt;

    // from the port
    assign in2_pb_src3_evt = in2_portb_mux_done[3];
    assign in2_pb_src2_evt = in2_portb_mux_done[2];
    assign in2_pb_src1_evt = in2_portb_mux_done[1];
    assign in2_pb_src0_evt = in2_portb_mux_done[0];

    // into the status word
    assign done_evt[`IN2_PORTB_LO + 3] = in2_pb_src3_evt;
    assign done_evt[`IN2_PORTB_LO + 2] = in2_pb_src2_evt;
    assign done_evt[`IN2_PORTB_LO + 1] = in2_pb_src1_evt;
    assign done_evt[`IN2_PORTB_LO + 0] = in2_pb_src0_evt;

    // ==========================================================
    // input 2 port a, lower luma client
    wire in2_pa_src15_evt;
    wire in2_pa_src14_evt;
    wire in2_pa_src13_evt;
    wire in2_pa_src12_evt;
    wire in2_pa_src11_evt;
    wire in2_pa_src10_evt;
    wire in2_pa_src9_evt;
    wire in2_pa_src8_evt;
    wire in2_pa_src7_evt;
    wire in2_pa_src6_evt;
    wire in2_pa_src5_evt;
    wire in2_pa_src4_evt;
    wire in2_pa_src3_evt;
    wire in2_pa_src2_evt;
    wire in2_pa_src1_evt;
    wire in2_pa_src0_evt;

    // from the port
    assign in2_pa_src15_evt = in2_porta_mux_done[15];
    assign in2_pa_src14_evt = in2_porta_mux_done[14];
    assign in2_pa_src13_evt = in2_porta_mux_done[13];
    assign in2_pa_src12_evt = in2_porta_mux_done[12];
    assign in2_pa_src11_evt = in2_porta_mux_done[11];
    assign in2_pa_src10_evt = in2_porta_mux_done[10];
    assign in2_pa_src9_evt = in2_porta_mux_done[9];
    assign in2_pa_src8_evt = in2_porta_mux_done[8];
    assign in2_pa_src7_evt = in2_porta_mux_done[7];
    assign in2_pa_src6_evt = in2_porta_mux_done[6];
    assign in2_pa_src5_evt = in2_porta_mux_done[5];
    assign in2_pa_src4_evt = in2_porta_mux_done[4];
    assign in2_pa_src3_evt = in2_porta_mux_done[3];
    assign in2_pa_src2_evt = in2_porta_mux_done[2];
    assign in2_pa_src1_evt = in2_porta_mux_done[1];
    assign in2_pa_src0_evt = in2_porta_mux_done[0];

    // into the status word
    assign done_evt[`IN2_PORTA_LO + 15] = in2_pa_src15_evt;
    assign done_evt[`IN2_PORTA_LO + 14] = in2_pa_src14_evt;
    assign done_evt[`IN2_PORTA_LO + 13] = in2_pa_src13_evt;
    assign done_evt[`IN2_PORTA_LO + 12] = in2_pa_src12_evt;
    assign done_evt[`IN2_PORTA_LO + 11] = in2_pa_src11_evt;
    assign done_evt[`IN2_PORTA_LO + 10] = in2_pa_src10_evt;
    assign done_evt[`IN2_PORTA_LO + 9] = in2_pa_src9_evt;
    assign done_evt[`IN2_PORTA_LO + 8] = in2_pa_src8_evt;
    assign done_evt[`IN2_PORTA_LO + 7] = in2_pa_src7_evt;
    assign done_evt[`IN2_PORTA_LO + 6] = in2_pa_src6_evt;
    assign done_evt[`IN2_PORTA_LO + 5] = in2_pa_src5_evt;
    assign done_evt[`IN2_PORTA_LO + 4] = in2_pa_src4_evt;
    assign done_evt[`IN2_PORTA_LO + 3] = in2_pa_src3_evt;
    assign done_evt[`IN2_PORTA_LO + 2] = in2_pa_src2_evt;
    assign done_evt[`IN2_PORTA_LO + 1] = in2_pa_src1_evt;
    assign done_evt[`IN2_PORTA_LO + 0] = in2_pa_src0_evt;

    // ==========================================================
    // input 1 video channels
    wire in1_pb_rgb_evt;
    wire in1_pa_rgb_evt;
    wire in1_pb_chroma_evt;
    wire in1_pb_luma_evt;
    wire in1_pa_chroma_evt;
    wire in1_pa_luma_evt;

    // from the port
    assign in1_pb_rgb_evt = in1_portb_rgb_done;
    assign in1_pa_rgb_evt = in1_porta_rgb_done;
    assign in1_pb_chroma_evt = in1_portb_chroma_done;
    assign in1_pb_luma_evt = in1_portb_luma_done;
    assign in1_pa_chroma_evt = in1_porta_chroma_done;
    assign in1_pa_luma_evt = in1_porta_luma_done;

    // into the status word
    assign done_evt[`IN1_PORTB_RGB_BIT] = in1_pb_rgb_evt;
    assign done_evt[`IN1_PORTA_RGB_BIT] = in1_pa_rgb_evt;
    assign done_evt[`IN1_PORTB_CHROMA_BIT] = in1_pb_chroma_evt;
    assign done_evt[`IN1_PORTB_LUMA_BIT] = in1_pb_luma_evt;
    assign done_evt[`IN1_PORTA_CHROMA_BIT] = in1_pa_chroma_evt;
    assign done_evt[`IN1_PORTA_LUMA_BIT] = in1_pa_luma_evt;

    // ==========================================================
    // input 1 port b ancillary sources
    // drain is the engine's promise; nothing here can check it
    wire in1_anc_src15_evt;
    wire in1_anc_src14_evt;
    wire in1_anc_src13_evt;
    wire in1_anc_src12_evt;
    wire in1_anc_src11_evt;
    wire in1_anc_src10_evt;

    // from the port
    assign in1_anc_src15_evt = in1_portb_anc_done[5];
    assign in1_anc_src14_evt = in1_portb_anc_done[4];
    assign in1_anc_src13_evt = in1_portb_anc_done[3];
    assign in1_anc_src12_evt = in1_portb_anc_done[2];
    assign in1_anc_src11_evt = in1_portb_anc_done[1];
    assign in1_anc_src10_evt = in1_portb_anc_done[0];

    // into the status word
    assign done_evt[`IN1_ANC_LO + 5] = in1_anc_src15_evt;
    assign done_evt[`IN1_ANC_LO + 4] = in1_anc_src14_evt;
    assign done_evt[`IN1_ANC_LO + 3] = in1_anc_src13_evt;
    assign done_evt[`IN1_ANC_LO + 2] = in1_anc_src12_evt;
    assign done_evt[`IN1_ANC_LO + 1] = in1_anc_src11_evt;
    assign done_evt[`IN1_ANC_LO + 0] = in1_anc_src10_evt;

    // ==========================================================
    // address decode
    // only an exact match counts; aliases would let a stray write clear status
    reg hit_status;
    reg hit_mask;
    reg wr_status;
    reg wr_mask;
    reg rd_status;
    reg rd_mask;
    reg rd_other;

    always @* begin
        hit_status = (reg_addr == `DONE_STATUS_OFS);
        hit_mask = (reg_addr == `DONE_MASK_OFS);
        wr_status = 1'b0;
        wr_mask = 1'b0;
        rd_status = 1'b0;
        rd_mask = 1'b0;
        rd_other = 1'b0;
        if (reg_wr) begin
            wr_status = hit_status;
            wr_mask = hit_mask;
        end
        if (reg_rd) begin
            rd_status = hit_status;
            rd_mask = hit_mask;
            rd_other = !hit_status && !hit_mask;
        end
    end

    // ==========================================================
    // write data lanes
    wire [DATA_W-1:0] clr_bits;
    wire [DATA_W-1:0] mask_wr_bits;

    assign clr_bits = wr_status ? reg_wdata : `DONE_RESET_VAL;
    assign mask_wr_bits = reg_wdata;

    // ==========================================================
    // state
    reg [DATA_W-1:0] status_q;
    reg [DATA_W-1:0] mask_q;
    reg [DATA_W-1:0] rdata_d;
    reg irq_d;
    wire [DATA_W-1:0] status_d;
    wire [DATA_W-1:0] mask_d;
    wire [DATA_W-1:0] irq_bits;

    // ==========================================================
    // per-bit next state
    // set is tested first so an event in the clear cycle survives
    genvar g;
    generate
        for (g = 0; g < DATA_W; g = g + 1) begin : bit_slice
            wire set_hit;
            wire clr_hit;
            wire mask_load;
            wire status_keep;
            reg status_nxt;
            reg mask_nxt;
            reg irq_nxt;

            assign set_hit = done_evt[g];
            assign clr_hit = clr_bits[g];
            assign mask_load = wr_mask;
            assign status_keep = status_q[g];

            always @* begin
                status_nxt = status_keep;
                if (set_hit) begin
                    status_nxt = `DONE_BIT_SET;
                end else if (clr_hit) begin
                    status_nxt = `DONE_BIT_CLR;
                end else begin
                    status_nxt = status_keep;
                end
            end

            always @* begin
                mask_nxt = mask_q[g];
                if (mask_load) begin
                    mask_nxt = mask_wr_bits[g];
                end else begin
                    mask_nxt = mask_q[g];
                end
            end

            always @* begin
                irq_nxt = `DONE_IRQ_IDLE;
                if (status_nxt && mask_nxt) begin
                    irq_nxt = `DONE_IRQ_ACTIVE;
                end
            end

            assign status_d[g] = status_nxt;
            assign mask_d[g] = mask_nxt;
            assign irq_bits[g] = irq_nxt;
        end
    endgenerate

    // ==========================================================
    // interrupt line
    // built from next state, so the line moves on the same edge as status
    always @* begin
        irq_d = `DONE_IRQ_IDLE;
        if (|irq_bits) begin
            irq_d = `DONE_IRQ_ACTIVE;
        end else begin
            irq_d = `DONE_IRQ_IDLE;
        end
    end

    // ==========================================================
    // read mux
    // unmapped reads return zero rather than stale data
    always @* begin
        rdata_d = `DONE_RESET_VAL;
        if (rd_status) begin
            rdata_d = status_q;
        end else if (rd_mask) begin
            rdata_d = mask_q;
        end else if (rd_other) begin
            rdata_d = `DONE_RESET_VAL;
        end else begin
            rdata_d = `DONE_RESET_VAL;
        end
    end

    // ==========================================================
    // status flops
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= `DONE_RESET_VAL;
        end else begin
            status_q <= status_d;
        end
    end

    // ==========================================================
    // mask flops
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= `DONE_RESET_VAL;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ==========================================================
    // read data flops
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `DONE_RESET_VAL;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // ==========================================================
    // interrupt flop
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dma_irq_line_zero <= `DONE_IRQ_IDLE;
        end else begin
            dma_irq_line_zero <= irq_d;
        end
    end
endmodule

// [test/dma_write_done_irq_status_asserts.sv]
`timescale 1ns/100ps
module irq_chk(input wire sys_clk, input wire rst_b, input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata, input wire reg_wr, input wire reg_rd, input wire [31:0] reg_rdata,
    input wire [3:0] in2_portb_mux_done, input wire [15:0] in2_porta_mux_done,
    input wire in1_porta_luma_done, input wire [5:0] in1_portb_anc_done,
    input wire dma_irq_line_zero);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire rs = reg_rd && reg_addr == 8'h58;
    a_unmapped_read: assert property (reg_rd && reg_addr != 8'h58 && reg_addr != 8'h5C
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_luma_sets: assert property (in1_porta_luma_done ##1 rs |=> reg_rdata[6])
        else $error("luma bit not set");
    a_in2b_sets: assert property (in2_portb_mux_done[3] ##1 rs |=> reg_rdata[31])
        else $error("bit 31 not set");
    a_in2a_sets: assert property (in2_porta_mux_done[0] ##1 rs |=> reg_rdata[12])
        else $error("bit 12 not set");
    a_anc_sets: assert property (in1_portb_anc_done[5] ##1 rs |=> reg_rdata[5])
        else $error("bit 5 not set");
    a_irq_holds: assert property (dma_irq_line_zero && !reg_wr |=> dma_irq_line_zero)
        else $error("irq dropped without write");
    a_zero_keeps: assert property (reg_wr && reg_addr == 8'h58 && reg_wdata == 32'h0 && dma_irq_line_zero
        |=> dma_irq_line_zero) else $error("zero write cleared");
    a_w1c_clear: assert property (reg_wr && reg_addr == 8'h58 && reg_wdata[6]
        && !in1_porta_luma_done ##1 rs |=> !reg_rdata[6]) else $error("bit 6 not cleared");
endmodule
bind dma_write_done_irq_status irq_chk irq_chk_inst(.*);

// [test/dma_write_done_irq_status_tb.sv]
`timescale 1ns/100ps
module dma_write_done_irq_status_tb;
    reg sys_clk = 0, rst_b = 0, wr = 0, rd = 0;
    reg [7:0] a = 0;
    reg [31:0] wd = 0, ev = 0;
    wire [31:0] q;
    wire irq;
    integer errors = 0, tests_run = 0, cyc = 0, i;
    always #20 sys_clk = ~sys_clk;
    // ev bits line up with status bits, so one shift walks every channel
    dma_write_done_irq_status dma_write_done_irq_status_inst(.sys_clk(sys_clk), .rst_b(rst_b),
        .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(q),
        .in2_portb_mux_done(ev[31:28]), .in2_porta_mux_done(ev[27:12]),
        .in1_portb_rgb_done(ev[11]), .in1_porta_rgb_done(ev[10]), .in1_portb_chroma_done(ev[9]),
        .in1_portb_luma_done(ev[8]), .in1_porta_chroma_done(ev[7]),
        .in1_porta_luma_done(ev[6]), .in1_portb_anc_done(ev[5:0]), .dma_irq_line_zero(irq));
    task chk(input string n, input [31:0] s, e);
        begin tests_run = tests_run + 1;
            if (s !== e) begin errors = errors + 1; $display("MISMATCH %s exp %h got %h", n, e, s); end
        end endtask
    task wrt(input [7:0] ad, input [31:0] d);
        begin a <= ad; wd <= d; wr <= 1; @(posedge sys_clk) wr <= 0; end endtask
    task rdc(input [7:0] ad, input [31:0] e);
        begin a <= ad; rd <= 1; @(posedge sys_clk) rd <= 0;
            @(negedge sys_clk) chk("rdata", q, e); @(posedge sys_clk); end endtask
    task evrd(input [31:0] v, e);
        begin ev <= v; @(posedge sys_clk) ev <= 0; rdc(8'h58, e); end endtask
    task finish_test;
        begin $display("checks %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish; end endtask
    always @(posedge sys_clk) begin cyc = cyc + 1;
        if (cyc == 3000) begin errors = errors + 1; finish_test; end end
    task t_reset;
        begin rdc(8'h58, 0); rdc(8'h5C, 0); rdc(8'h60, 0);
            $display("reset test done"); end endtask
    task t_walk;
        begin for (i = 0; i < 32; i = i + 1) begin
                evrd(32'h1 << i, 32'h1 << i);
                wrt(8'h58, 32'h1 << i); rdc(8'h58, 0); end
            $display("walk test done"); end endtask
    task t_irq;
        begin wrt(8'h5C, 32'h40); rdc(8'h5C, 32'h40);
            evrd(32'h80, 32'h80); chk("irq", irq, 0);
            evrd(32'h40, 32'hC0); chk("irq", irq, 1);
            wrt(8'h58, 0); rdc(8'h58, 32'hC0);
            ev <= 32'h40; wrt(8'h58, 32'h40); evrd(0, 32'hC0);
            wrt(8'h58, 32'hC0); rdc(8'h58, 0); chk("irq", irq, 0);
            $display("irq test done"); end endtask
    initial begin repeat (4) @(posedge sys_clk); rst_b <= 1; @(posedge sys_clk);
        t_reset; t_walk; t_irq; finish_test; end
endmodule
